// [sll_consts.svh]
`ifndef SLL_CONSTS_SVH
`define SLL_CONSTS_SVH
`define SLL_WORD_BITS 24
`define SLL_SEL_REF 2'h0
`define SLL_SEL_AB 2'h1
`define SLL_SEL_FUNC 2'h2
`define SLL_SEL_INIT 2'h3
`define SLL_FUNC_RESET 24'h000000
`define SLL_CP_TRI_BIT 11
`define SLL_MUX_LSB 4
`define SLL_MUX_LOCK 3'h1
`define SLL_MAX_SCLK_MHZ 20
`endif

// [sll_pkg.sv]
package sll_pkg;
   typedef enum logic [1:0] {
      SLL_LATCH_REF,
      SLL_LATCH_AB,
      SLL_LATCH_FUNC,
      SLL_LATCH_INIT
   } sll_latch_t;
   typedef struct packed {
      logic [23:0] word;
   } sll_latch_word_t;
endpackage

// [sll_sync.sv]
`timescale 1ns/1ps
module sll_sync (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   input wire logic async_in,
   output logic sync_out
);
   typedef struct packed {
      logic meta;
      logic sync;
   } sll_sync_state_t;
   sll_sync_state_t s_q;
   sll_sync_state_t s_d;
   always_comb begin
      s_d = s_q;
      if (clk_en_in) begin
         s_d.meta = async_in;
         s_d.sync = s_q.meta;
      end
   end
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign sync_out = s_q.sync;
endmodule

// [sll_top.sv]
`timescale 1ns/1ps
`include "sll_consts.svh"
// Summary of operation
// RULE1: Shift data on rising serial clock edges.
// RULE2: Strobe rise copies word to selected latch.
// RULE3: Serial clock up to 20 MHz accepted.
// RULE4: Host frames words as three bytes.
// RULE5: Host raises strobe after third byte.
// RULE6: Output active after ref, N, init writes.
// RULE7: Host controls power, polls test output.
// RULE8: Two low bits select destination latch.
// RULE9: Init load resets counters, tristates pump.
// RULE10: Power enable low powers down, keeps latches.
// RULE11: Most significant bit shifted in first.
module sll_top #(
   parameter int WORD_BITS = `SLL_WORD_BITS
) (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   input wire logic serial_clock_pin_in,
   input wire logic serial_data_pin_in,
   input wire logic latch_load_strobe_in,
   input wire logic chip_power_enable_in,
   input wire logic lock_indicator_in,
   output logic [23:0] ref_latch_out,
   output logic [23:0] ab_latch_out,
   output logic [23:0] func_latch_out,
   output logic counter_reset_out,
   output logic charge_pump_tristate_out,
   output logic powered_down_out,
   output logic output_active_out,
   output logic multiplexed_test_output_out
);
   typedef struct packed {
      logic sclk_prev;
      logic le_prev;
      logic [WORD_BITS-1:0] shift;
      sll_pkg::sll_latch_word_t ref_l;
      sll_pkg::sll_latch_word_t ab_l;
      sll_pkg::sll_latch_word_t func_l;
      logic init_pending;
      logic cnt_rst;
      logic pd;
      logic got_ref;
      logic got_ab;
      logic got_init;
      logic active;
      logic muxo;
      logic cp_tri;
   } sll_state_t;
   sll_state_t s_q;
   sll_state_t s_d;
   logic sclk_s;
   logic serial_data_pin_s;
   logic le_s;
   logic ce_s;
   logic ld_s;
   sll_sync u_sync_sclk (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .async_in(serial_clock_pin_in),
      .sync_out(sclk_s)
   );
   sll_sync u_sync_serial_data_pin (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .async_in(serial_data_pin_in),
      .sync_out(serial_data_pin_s)
   );
   sll_sync u_sync_le (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .async_in(latch_load_strobe_in),
      .sync_out(le_s)
   );
   sll_sync u_sync_ce (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .async_in(chip_power_enable_in),
      .sync_out(ce_s)
   );
   sll_sync u_sync_ld (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .async_in(lock_indicator_in),
      .sync_out(ld_s)
   );
   logic sclk_rise;
   logic le_rise;
   logic [1:0] sel;
   // RULE8: select field decode.
   function automatic logic [1:0] latch_sel(input logic [WORD_BITS-1:0] word);
      return word[1:0];
   endfunction
   always_comb begin
      sclk_rise = sclk_s & ~s_q.sclk_prev;
      le_rise = le_s & ~s_q.le_prev;
      sel = latch_sel(s_q.shift);
      s_d = s_q;
      s_d.sclk_prev = sclk_s;
      s_d.le_prev = le_s;
      s_d.cnt_rst = 1'b0;
      // RULE10: power-down follows inverted enable.
      s_d.pd = ~ce_s;
      // RULE1: shift one bit.
      // RULE11: MSB first order.
      // RULE3: edge sampled at 40 MHz.
      if (sclk_rise && !le_s) begin
         s_d.shift = {s_q.shift[WORD_BITS-2:0], serial_data_pin_s};
      end
      // RULE2: strobe rise latches word.
      if (le_rise) begin
         // RULE8: select by low bits.
         case (sel)
            `SLL_SEL_REF: begin
               s_d.ref_l.word = s_q.shift[23:0];
               s_d.got_ref = 1'b1;
            end
            `SLL_SEL_AB: begin
               s_d.ab_l.word = s_q.shift[23:0];
               s_d.got_ab = 1'b1;
               if (s_q.init_pending) begin
                  s_d.cnt_rst = 1'b1;
                  s_d.init_pending = 1'b0;
               end
            end
            `SLL_SEL_FUNC: begin
               s_d.func_l.word = s_q.shift[23:0];
            end
            default: begin
               // RULE9: init loads function, resets.
               s_d.func_l.word = s_q.shift[23:0];
               s_d.cnt_rst = 1'b1;
               s_d.init_pending = 1'b1;
               s_d.got_init = 1'b1;
            end
         endcase
      end
      // RULE6: active after three writes.
      s_d.active = s_d.got_ref & s_d.got_ab & s_d.got_init & ~s_d.pd;
      // RULE9: pump tristate registered.
      s_d.cp_tri = s_d.cnt_rst | s_d.func_l.word[`SLL_CP_TRI_BIT] | s_d.pd;
      // RULE7: test output shows lock.
      if (s_q.func_l.word[`SLL_MUX_LSB+2:`SLL_MUX_LSB] == `SLL_MUX_LOCK) begin
         s_d.muxo = ld_s;
      end else begin
         s_d.muxo = 1'b0;
      end
   end
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         s_q <= '0;
         s_q.pd <= 1'b1;
         s_q.cp_tri <= 1'b1;
      end else if (clk_en_in) begin
         s_q <= s_d;
      end
   end
   assign ref_latch_out = s_q.ref_l.word;
   assign ab_latch_out = s_q.ab_l.word;
   assign func_latch_out = s_q.func_l.word;
   assign counter_reset_out = s_q.cnt_rst;
   assign charge_pump_tristate_out = s_q.cp_tri;
   assign powered_down_out = s_q.pd;
   assign output_active_out = s_q.active;
   assign multiplexed_test_output_out = s_q.muxo;
   // RULE2: strobe rise lands in latch.
   latch_load_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE2
      clk_en_in && le_rise && sel == `SLL_SEL_REF |=> ref_latch_out == $past(s_q.shift))
      else $error("reference latch not loaded");
   // RULE9: init pulses counter reset.
   init_reset_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE9
      clk_en_in && le_rise && sel == `SLL_SEL_INIT
      |=> counter_reset_out && charge_pump_tristate_out)
      else $error("init load gave no reset pulse");
   // RULE10: retained across power-down.
   pd_keep_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE10
      clk_en_in && !le_rise |=> $stable(ab_latch_out))
      else $error("latch changed without load");
   // RULE1: shift on serial edge.
   shift_edge_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE1
      clk_en_in && sclk_rise && !le_s |=> s_q.shift[0] == $past(serial_data_pin_s))
      else $error("bit not shifted in");
   // RULE6: active needs all writes.
   active_gate_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE6
      output_active_out |-> s_q.got_ref && s_q.got_ab && s_q.got_init)
      else $error("output active too early");
   // RULE1: shift held during strobe.
   shift_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE1
      clk_en_in && le_s |=> s_q.shift == $past(s_q.shift))
      else $error("shift moved while strobe high");
   // RULE8: AB select loads AB.
   ab_select_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE8
      clk_en_in && le_rise && sel == `SLL_SEL_AB |=> ab_latch_out == $past(s_q.shift))
      else $error("AB latch not loaded");
   // RULE8: function select loads function.
   func_select_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE8
      clk_en_in && le_rise && sel == `SLL_SEL_FUNC |=> func_latch_out == $past(s_q.shift))
      else $error("function latch not loaded");
   // RULE9: init loads function settings.
   init_func_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE9
      clk_en_in && le_rise && sel == `SLL_SEL_INIT |=> func_latch_out == $past(s_q.shift))
      else $error("init did not load function settings");
   // RULE9: reset pulse lasts one cycle.
   pulse_once_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE9
      clk_en_in && counter_reset_out |=> !counter_reset_out)
      else $error("counter reset pulse too long");
   // RULE10: enable low powers down.
   power_down_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE10
      clk_en_in && !ce_s |=> powered_down_out && !output_active_out)
      else $error("power-down not applied");
   // RULE10: pump tristate when down.
   tristate_pd_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE10
      powered_down_out |-> charge_pump_tristate_out)
      else $error("pump driven while powered down");
   // RULE7: test output gated by code.
   mux_gate_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE7
      clk_en_in && func_latch_out[`SLL_MUX_LSB+2:`SLL_MUX_LSB] != `SLL_MUX_LOCK
      |=> !multiplexed_test_output_out)
      else $error("test output shown without lock code");
endmodule

// [sll_host_model.sv]
`timescale 1ns/1ps
module sll_host_model (
   output logic sclk_out,
   output logic serial_data_pin_out,
   output logic strobe_out
);
   initial begin
      sclk_out = 1'b0;
      serial_data_pin_out = 1'b0;
      strobe_out = 1'b0;
   end
   task automatic send(input logic [23:0] w);
      strobe_out = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         serial_data_pin_out = w[i];
         #100 sclk_out = 1'b1;
         #100 sclk_out = 1'b0;
      end
      serial_data_pin_out = ~w[0];
      #100 strobe_out = 1'b1;
      #200 strobe_out = 1'b0;
   endtask
endmodule

// [serial_latch_load_interface_bench.sv]
`timescale 1ns/1ps
module serial_latch_load_interface_bench;
   logic sys_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic ce = 1'b1;
   logic en = 1'b1;
   logic lock = 1'b1;
   logic sclk, serial_data_pin, strobe, crst, cpt, pdn, act, mux;
   logic [23:0] ref_q, ab_q, func_q;
   int n_mismatch = 0;
   int num_checks = 0;
   int n_pulse = 0;
   always #12.5 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) begin
      if (crst === 1'b1) n_pulse++;
   end
   sll_host_model sll_host_model_i (.sclk_out(sclk), .serial_data_pin_out(serial_data_pin), .strobe_out(strobe));
   sll_top sll_top_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .clk_en_in(en),
      .serial_clock_pin_in(sclk), .serial_data_pin_in(serial_data_pin),
      .latch_load_strobe_in(strobe), .chip_power_enable_in(ce),
      .lock_indicator_in(lock), .ref_latch_out(ref_q), .ab_latch_out(ab_q),
      .func_latch_out(func_q), .counter_reset_out(crst),
      .charge_pump_tristate_out(cpt), .powered_down_out(pdn),
      .output_active_out(act), .multiplexed_test_output_out(mux));
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic load(input logic [23:0] w);
      sll_host_model_i.send(w);
      repeat (4) @(negedge sys_clk_in);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic t_init();
      load(24'h000803);
      chk(func_q, 24'h000803);
      chk(24'(n_pulse), 24'h000001);
      chk(24'(cpt), 24'h000001);
      chk(24'(act), 24'h000000);
   endtask
   task automatic t_ref_ab();
      load(24'h123450);
      chk(ref_q, 24'h123450);
      load(24'habcde1);
      chk(ab_q, 24'habcde1);
      chk(24'(n_pulse), 24'h000002);
      chk(24'(act), 24'h000001);
      load(24'h000005);
      chk(ab_q, 24'h000005);
      chk(24'(n_pulse), 24'h000002);
      chk(ref_q, 24'h123450);
   endtask
   task automatic t_func_lock();
      load(24'h000012);
      chk(func_q, 24'h000012);
      chk(24'(cpt), 24'h000000);
      chk(24'(mux), 24'h000001);
      lock = 1'b0;
      repeat (5) @(negedge sys_clk_in);
      chk(24'(mux), 24'h000000);
      lock = 1'b1;
      repeat (5) @(negedge sys_clk_in);
      chk(24'(mux), 24'h000001);
   endtask
   task automatic t_freeze();
      en = 1'b0;
      load(24'h000002);
      chk(func_q, 24'h000012);
      en = 1'b1;
      repeat (5) @(negedge sys_clk_in);
      chk(func_q, 24'h000012);
      load(24'h000002);
      chk(func_q, 24'h000002);
      chk(24'(mux), 24'h000000);
   endtask
   task automatic t_power();
      ce = 1'b0;
      repeat (5) @(negedge sys_clk_in);
      chk(24'(pdn), 24'h000001);
      chk(24'(act), 24'h000000);
      chk(24'(cpt), 24'h000001);
      chk(ref_q, 24'h123450);
      ce = 1'b1;
      repeat (5) @(negedge sys_clk_in);
      chk(24'(act), 24'h000001);
   endtask
   initial begin
      #200000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (2) @(negedge sys_clk_in);
      rst_n_in = 1'b1;
      t_init();
      t_ref_ab();
      t_func_lock();
      t_power();
      t_freeze();
      report_and_stop();
   end
endmodule
